/* File: src/chg_pkg.sv */
// Purpose: Shared constants and types of the charger control register block.
// Assumes: A 25 MHz system clock and an 8-bit register address space.
// Notes:   Times are kept in their own units; cycle counts derive from them.
package chg_pkg;

  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned WDOG_TIME_S   = 14;
  localparam int unsigned IVAL_TIME_S   = 1;
  localparam int unsigned HOLD_TIME_US  = 100;
  localparam int unsigned WDOG_CYC_DEF  = WDOG_TIME_S * CLK_HZ;
  localparam int unsigned IVAL_CYC_DEF  = IVAL_TIME_S * CLK_HZ;
  localparam int unsigned HOLD_CYC_DEF  = (HOLD_TIME_US * (CLK_HZ / 1000) + 999) / 1000;

  localparam logic [7:0] ADDR_CTRL2     = 8'h37;
  localparam logic [7:0] ADDR_THERMISTOR_READ_CONTROL   = 8'h40;
  localparam logic [7:0] ADDR_FAULT     = 8'h58;
  localparam logic [7:0] ADDR_FASTCHG   = 8'h61;

  localparam logic [7:0] CTRL2_RST      = 8'h40;
  localparam logic [7:0] THERMISTOR_READ_CONTROL_RST    = 8'h02;
  localparam logic [7:0] FAULT_RST      = 8'h00;
  localparam logic [7:0] FASTCHG_RST    = 8'h34;
  localparam logic [7:0] THERMISTOR_READ_CONTROL_WMASK  = 8'hBF;

  localparam int INHIBIT_BIT  = 0;
  localparam int WDOG_EN_BIT  = 1;
  localparam int GPO_BIT      = 4;
  localparam int RAIL_LSB     = 5;
  localparam int TRIG_BIT     = 5;
  localparam int INTERVAL_BIT = 7;
  localparam int MEAS_EN_BIT  = 2;
  localparam int VDROP_LSB    = 4;
  localparam int ISCALE_LSB   = 0;

  localparam logic [1:0] ZONE_NORMAL = 2'h0;
  localparam logic [1:0] ZONE_COOL   = 2'h1;
  localparam logic [1:0] ZONE_WARM   = 2'h2;

  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_ACKA, I_REG, I_ACKR, I_WDAT, I_ACKW, I_RDAT, I_RACK
  } chg_i2c_e;

endpackage

/* File: src/chg_reg_if.sv */
// Purpose: Register access path between the serial target and the register bank.
// Assumes: All signals are on clk_sys.
// Notes:   rdata is combinational from the bank for the current pointer.
`timescale 1ns/100ps
interface chg_reg_if;
  logic       wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       txn_done;
  logic       sda_oe;
  modport target (output wr_stb, output addr, output wdata, output txn_done, output sda_oe, input rdata);
  modport regs   (input wr_stb, input addr, input wdata, input txn_done, input sda_oe, output rdata);
endinterface

/* File: src/chg_i2c_target.sv */
// Purpose: Serial two-wire target that turns host transfers into register writes and reads.
// Assumes: SCL is slow against clk_sys; pins pass three flops before use.
// Notes:   Register pointer auto-increments after every data byte written and every read byte the host acknowledges.
`timescale 1ns/100ps
module chg_i2c_target
  import chg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary neutral target address.
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic scl,
  input  wire logic sda_i,
  chg_reg_if.target bus
);

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic       scl_f;
    logic       sda_f;
    chg_i2c_e   st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       rd;
    logic       hit;
    logic       oe;
    logic       wr;
    logic       txn;
  } chg_i2c_s;

  chg_i2c_s q_ff;
  chg_i2c_s nxt_q;
  logic     rise;
  logic     fall;
  logic     start;
  logic     stop;

  always_comb begin
    nxt_q       = q_ff;
    nxt_q.wr    = 1'b0;
    nxt_q.txn   = 1'b0;
    nxt_q.scl_s = {q_ff.scl_s[1:0], scl};
    nxt_q.sda_s = {q_ff.sda_s[1:0], sda_i};
    // A level is taken only once the second and third flops agree.
    if (q_ff.scl_s[2] == q_ff.scl_s[1]) begin
      nxt_q.scl_f = q_ff.scl_s[2];
    end
    if (q_ff.sda_s[2] == q_ff.sda_s[1]) begin
      nxt_q.sda_f = q_ff.sda_s[2];
    end
    rise  = nxt_q.scl_f & ~q_ff.scl_f;
    fall  = ~nxt_q.scl_f & q_ff.scl_f;
    start = q_ff.scl_f & nxt_q.scl_f & q_ff.sda_f & ~nxt_q.sda_f;
    stop  = q_ff.scl_f & nxt_q.scl_f & ~q_ff.sda_f & nxt_q.sda_f;
    if (start || stop) begin
      nxt_q.st  = start ? I_ADDR : I_IDLE;
      nxt_q.cnt = 4'h0;
      nxt_q.oe  = 1'b0;
      if (stop) begin
        nxt_q.txn = q_ff.hit;
        nxt_q.hit = 1'b0;
      end
    end else if (rise) begin
      case (q_ff.st)
        I_ADDR, I_REG, I_WDAT: begin
          nxt_q.sh  = {q_ff.sh[6:0], nxt_q.sda_f};
          nxt_q.cnt = q_ff.cnt + 4'h1;
        end
        I_RDAT: nxt_q.cnt = q_ff.cnt + 4'h1;
        I_RACK: begin
          // A not-acknowledge ends the read burst.
          if (nxt_q.sda_f) begin
            nxt_q.st = I_IDLE;
          end else begin
            nxt_q.ptr = q_ff.ptr + 8'h01;
          end
        end
        default: ;
      endcase
    end else if (fall) begin
      unique case (q_ff.st)
        I_IDLE: ;
        I_ADDR: begin
          if (q_ff.cnt == 4'h8) begin
            if (q_ff.sh[7:1] == DEV_ADDR) begin
              nxt_q.oe  = 1'b1;
              nxt_q.rd  = q_ff.sh[0];
              nxt_q.hit = 1'b1;
              nxt_q.st  = I_ACKA;
            end else begin
              nxt_q.st = I_IDLE;
            end
          end
        end
        I_ACKA, I_RACK: begin
          nxt_q.cnt = 4'h0;
          if (q_ff.rd) begin
            nxt_q.st = I_RDAT;
            nxt_q.sh = bus.rdata;
            nxt_q.oe = ~bus.rdata[7];
          end else begin
            nxt_q.st = I_REG;
            nxt_q.oe = 1'b0;
          end
        end
        I_REG: begin
          if (q_ff.cnt == 4'h8) begin
            nxt_q.ptr = q_ff.sh;
            nxt_q.oe  = 1'b1;
            nxt_q.st  = I_ACKR;
          end
        end
        I_ACKR, I_ACKW: begin
          nxt_q.oe  = 1'b0;
          nxt_q.cnt = 4'h0;
          nxt_q.st  = I_WDAT;
          if (q_ff.st == I_ACKW) begin
            nxt_q.ptr = q_ff.ptr + 8'h01;
          end
        end
        I_WDAT: begin
          if (q_ff.cnt == 4'h8) begin
            nxt_q.wr = 1'b1;
            nxt_q.oe = 1'b1;
            nxt_q.st = I_ACKW;
          end
        end
        I_RDAT: begin
          if (q_ff.cnt == 4'h8) begin
            nxt_q.oe = 1'b0;
            nxt_q.st = I_RACK;
          end else begin
            nxt_q.oe = ~q_ff.sh[3'h7 - q_ff.cnt[2:0]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q_ff <= '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1, st: I_IDLE, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign bus.wr_stb   = q_ff.wr;
  assign bus.addr     = q_ff.ptr;
  assign bus.wdata    = q_ff.sh;
  assign bus.txn_done = q_ff.txn;
  assign bus.sda_oe   = q_ff.oe;

endmodule

/* File: src/chg_ctrl_regs.sv */
// Purpose: Charger control and thermal register bank with host-silence watchdog.
// Assumes: Zone, supply and read-done inputs come from on-chip logic on clk_sys.
// Notes:   The charge-enable pin is asynchronous and passes three flops.
`timescale 1ns/100ps
//Contract
// - Bits 7-5 pick rail target: tracking, 4.4-4.9 V, or pass-through; default 010.
// - Bit 4 sets status pin as GPO: zero pulls low, one releases.
// - With bit 1 set, no host transfer 14 s after supply forces hardware reset.
// - Watchdog enable resets to zero.
// - Bit 0 inhibits charge; when clear, charge follows low charge-enable pin.
// - On battery only, interval bit selects manual or one-second thermistor checks.
// - Writing trigger starts a thermistor read; hardware clears it when done.
// - Fault measurement enable bit 2, reset disabled.
// - Warm zone drops battery target by code times 50 mV; default 011.
// - Reduced-zone current scales to one minus code/8; default 100.
// - Reduction register at 0x61 resets 0x34; read 0x2; measurement 0x0.
// - Status pin follows GPO bit only when mode upper bit is one.
// - Hardware reset drops rails briefly and returns registers to defaults.
module chg_ctrl_regs
  import chg_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR = 7'h2A,  // Arbitrary neutral target address.
  parameter int unsigned WDOG_CYC = chg_pkg::WDOG_CYC_DEF,
  parameter int unsigned IVAL_CYC = chg_pkg::IVAL_CYC_DEF,
  parameter int unsigned HOLD_CYC = chg_pkg::HOLD_CYC_DEF
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       scl,
  input  wire logic       sda_i,
  output wire logic       sda_o,
  output wire logic       sda_oe,
  input  wire logic       charge_en_b,
  input  wire logic       input_supply_present,
  input  wire logic       input_power_good,
  input  wire logic       button_level,
  input  wire logic [1:0] status_pin_mode,
  input  wire logic [1:0] temp_zone,
  input  wire logic       temp_read_done,
  output wire logic [2:0] system_rail_target_sel,
  output wire logic       status_pin_o,
  output wire logic       status_pin_oe,
  output wire logic       charge_allow,
  output wire logic [2:0] warm_volt_drop_sel,
  output wire logic [2:0] zone_current_scale_sel,
  output wire logic       temp_meas_en,
  output wire logic       temp_check_trigger,
  output wire logic       temp_read_req,
  output wire logic       rails_off
);
  import chg_pkg::*;

  if (WDOG_CYC < 2 || IVAL_CYC < 2 || HOLD_CYC < 1) begin : g_bad_count
    $error("Cycle counts too small for the counters");
  end

  typedef struct packed {
    logic [7:0]  ctrl2;
    logic [7:0]  thermistor_read_control;
    logic [7:0]  fault;
    logic [7:0]  fastchg;
    logic [2:0]  ce_s;
    logic        ce_b_f;
    logic        sup_prev;
    logic        wd_armed;
    logic [31:0] wd_cnt;
    logic [31:0] iv_cnt;
    logic [31:0] hold_cnt;
    logic        rails_off;
    logic [2:0]  rail_sel;
    logic        pin_oe;
    logic        chg_allow;
    logic [2:0]  vdrop;
    logic [2:0]  iscale;
    logic        meas_en;
    logic        rd_req;
  } chg_regs_s;

  chg_reg_if bus ();
  chg_regs_s q_ff;
  chg_regs_s nxt_q;
  logic      trig_wr;
  logic      wd_fire;

  chg_i2c_target #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .scl     (scl),
    .sda_i   (sda_i),
    .bus     (bus)
  );

  always_comb begin
    unique case (bus.addr)
      ADDR_CTRL2:   bus.rdata = q_ff.ctrl2;
      ADDR_THERMISTOR_READ_CONTROL: bus.rdata = q_ff.thermistor_read_control;
      ADDR_FAULT:   bus.rdata = q_ff.fault;
      ADDR_FASTCHG: bus.rdata = q_ff.fastchg;
      default:      bus.rdata = 8'h00;
    endcase
  end

  always_comb begin
    nxt_q        = q_ff;
    nxt_q.rd_req = 1'b0;
    trig_wr      = bus.wr_stb && (bus.addr == ADDR_THERMISTOR_READ_CONTROL) && bus.wdata[TRIG_BIT];
    wd_fire      = 1'b0;
    nxt_q.ce_s   = {q_ff.ce_s[1:0], charge_en_b};
    if (q_ff.ce_s[2] == q_ff.ce_s[1]) begin
      nxt_q.ce_b_f = q_ff.ce_s[2];
    end
    if (bus.wr_stb) begin
      unique case (bus.addr)
        ADDR_CTRL2:   nxt_q.ctrl2   = bus.wdata;
        ADDR_THERMISTOR_READ_CONTROL: nxt_q.thermistor_read_control = bus.wdata & THERMISTOR_READ_CONTROL_WMASK;
        ADDR_FAULT:   nxt_q.fault   = bus.wdata;
        ADDR_FASTCHG: nxt_q.fastchg = bus.wdata;
        default: ;
      endcase
    end
    // A host write of one in the same cycle as completion keeps the new request.
    if (temp_read_done && !trig_wr) begin
      nxt_q.thermistor_read_control[TRIG_BIT] = 1'b0;
    end
    nxt_q.rd_req = trig_wr;
    if (q_ff.thermistor_read_control[INTERVAL_BIT] && !input_supply_present) begin
      if (q_ff.iv_cnt == 32'h0) begin
        nxt_q.rd_req = 1'b1;
        nxt_q.iv_cnt = 32'(IVAL_CYC - 1);
      end else begin
        nxt_q.iv_cnt = q_ff.iv_cnt - 32'h1;
      end
    end else begin
      nxt_q.iv_cnt = 32'(IVAL_CYC - 1);
    end
    // The silence timer starts on supply arrival; any addressed transfer ends it.
    nxt_q.sup_prev = input_supply_present;
    if (input_supply_present && !q_ff.sup_prev) begin
      nxt_q.wd_armed = 1'b1;
      nxt_q.wd_cnt   = 32'(WDOG_CYC - 1);
    end else if (q_ff.wd_armed) begin
      if (bus.txn_done || !input_supply_present) begin
        nxt_q.wd_armed = 1'b0;
      end else if (q_ff.wd_cnt == 32'h0) begin
        nxt_q.wd_armed = 1'b0;
        wd_fire        = q_ff.ctrl2[WDOG_EN_BIT];
      end else begin
        nxt_q.wd_cnt = q_ff.wd_cnt - 32'h1;
      end
    end
    if (q_ff.rails_off) begin
      if (q_ff.hold_cnt == 32'h0) begin
        nxt_q.rails_off = 1'b0;
      end else begin
        nxt_q.hold_cnt = q_ff.hold_cnt - 32'h1;
      end
    end
    if (wd_fire) begin
      nxt_q.ctrl2     = CTRL2_RST;
      nxt_q.thermistor_read_control   = THERMISTOR_READ_CONTROL_RST;
      nxt_q.fault     = FAULT_RST;
      nxt_q.fastchg   = FASTCHG_RST;
      nxt_q.rails_off = 1'b1;
      nxt_q.hold_cnt  = 32'(HOLD_CYC - 1);
      nxt_q.rd_req    = 1'b0;
    end
    nxt_q.rail_sel = q_ff.ctrl2[RAIL_LSB +: 3];
    if (status_pin_mode[1]) begin
      nxt_q.pin_oe = ~q_ff.ctrl2[GPO_BIT];
    end else if (status_pin_mode[0]) begin
      nxt_q.pin_oe = ~button_level;
    end else begin
      nxt_q.pin_oe = input_power_good;
    end
    nxt_q.chg_allow = ~q_ff.ctrl2[INHIBIT_BIT] & ~q_ff.ce_b_f & ~q_ff.rails_off;
    nxt_q.vdrop     = (temp_zone == ZONE_WARM) ? q_ff.fastchg[VDROP_LSB +: 3] : 3'h0;
    nxt_q.iscale    = (temp_zone == ZONE_WARM || temp_zone == ZONE_COOL) ?
                      q_ff.fastchg[ISCALE_LSB +: 3] : 3'h0;
    nxt_q.meas_en   = q_ff.fault[MEAS_EN_BIT];
  end

  // Register defaults come from constants only.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q_ff <= '{ctrl2: CTRL2_RST, thermistor_read_control: THERMISTOR_READ_CONTROL_RST, fault: FAULT_RST, fastchg: FASTCHG_RST,
                ce_s: 3'h7, ce_b_f: 1'b1, rail_sel: CTRL2_RST[7:5], default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign sda_o                  = 1'b0;
  assign sda_oe                 = bus.sda_oe;
  assign system_rail_target_sel = q_ff.rail_sel;
  assign status_pin_o           = 1'b0;
  assign status_pin_oe          = q_ff.pin_oe;
  assign charge_allow           = q_ff.chg_allow;
  assign warm_volt_drop_sel     = q_ff.vdrop;
  assign zone_current_scale_sel = q_ff.iscale;
  assign temp_meas_en           = q_ff.meas_en;
  assign temp_check_trigger     = q_ff.thermistor_read_control[TRIG_BIT];
  assign temp_read_req          = q_ff.rd_req;
  assign rails_off              = q_ff.rails_off;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_trig_write;
    trig_wr;
  endsequence
  sequence s_read_done;
    q_ff.thermistor_read_control[TRIG_BIT] && temp_read_done && !trig_wr;
  endsequence

  a_trig_starts_read: assert property (s_trig_write ##0 !wd_fire |=> temp_read_req && temp_check_trigger)
    else $error("trigger write did not start a read");
  a_trig_self_clear: assert property (s_read_done |=> !temp_check_trigger)
    else $error("trigger bit not cleared after read");
  a_auto_interval: assert property (q_ff.thermistor_read_control[INTERVAL_BIT] && !input_supply_present && q_ff.iv_cnt == 32'h0
                                    && !wd_fire |=> temp_read_req)
    else $error("interval read missing");
  a_inhibit_blocks: assert property (q_ff.ctrl2[INHIBIT_BIT] |=> !charge_allow)
    else $error("charge allowed while inhibited");
  a_rail_follows: assert property (##1 system_rail_target_sel == $past(q_ff.ctrl2[7:5]))
    else $error("rail target does not follow register");
  a_gpo_pulls: assert property (status_pin_mode[1] && !q_ff.ctrl2[GPO_BIT] |=> status_pin_oe)
    else $error("status pin not pulled low");
  a_wdog_fires: assert property (q_ff.wd_armed && q_ff.wd_cnt == 32'h0 && input_supply_present && !bus.txn_done
                                 && q_ff.ctrl2[WDOG_EN_BIT] |=> rails_off && q_ff.ctrl2 == CTRL2_RST)
    else $error("watchdog expiry without hardware reset");
  a_reset_defaults: assert property ($rose(rails_off) |-> q_ff.fastchg == FASTCHG_RST && q_ff.fault == FAULT_RST
                                     && q_ff.thermistor_read_control == THERMISTOR_READ_CONTROL_RST)
    else $error("registers not at defaults after hardware reset");
  a_warm_only_drop: assert property (temp_zone != ZONE_WARM |=> warm_volt_drop_sel == 3'h0)
    else $error("voltage drop outside warm zone");
  a_cool_scale: assert property (temp_zone == ZONE_COOL |=> zone_current_scale_sel == $past(q_ff.fastchg[2:0]))
    else $error("current scale not applied in cool zone");
  a_meas_enable: assert property (##1 temp_meas_en == $past(q_ff.fault[MEAS_EN_BIT]))
    else $error("measurement enable does not follow register");

endmodule

/* File: dv/chg_host_model.sv */
// Purpose: Behavioural two-wire host that writes and reads the charger registers.
// Assumes: The bench resolves the open-drain data line, with a pull-up when released.
// Notes:   A half bit is 8 clk_sys cycles, twice the shortest phase the target accepts.
`timescale 1ns/100ps
module chg_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary neutral target address.
) (
  input  wire logic       clk_sys,
  input  wire logic       sda_line,
  output logic            scl,
  output logic            sda_oe,
  output logic [7:0]      rd_data,
  output logic            rd_valid
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
    rd_data = 8'h00;
    rd_valid = 1'b0;
  end

  task automatic half();
    repeat (8) @(posedge clk_sys);
  endtask

  // Data only changes while the clock is low, so no false start or stop is seen.
  task automatic put_bit(input logic b);
    sda_oe <= ~b;
    half();
    scl <= 1'b1;
    half();
    scl <= 1'b0;
  endtask

  task automatic get_bit(output logic b);
    sda_oe <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    b = sda_line;
    scl <= 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] d);
    logic ack;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(ack);
  endtask

  task automatic start();
    sda_oe <= 1'b1;
    half();
    scl <= 1'b0;
  endtask

  task automatic stop();
    sda_oe <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_oe <= 1'b0;
    half();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(a);
    send_byte(d);
    stop();
  endtask

  task automatic rd(input logic [7:0] a);
    logic [7:0] d;
    start();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(a);
    sda_oe <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    start();
    send_byte({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'b1);
    stop();
    rd_data <= d;
    rd_valid <= 1'b1;
    @(posedge clk_sys);
    rd_valid <= 1'b0;
  endtask
endmodule

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for the charger control register bank.
// Assumes: Shortened watchdog, interval and hold counts; outputs compared from a note queue.
// Notes:   Expected output vectors are rebuilt from shadow registers and the bench's inputs.
`timescale 1ns/100ps
module testbench;
  import chg_pkg::*;
  typedef struct { string name; logic [20:0] v; } chg_note_s;
  localparam int IVAL = 50;
  localparam int HOLD = 4;
  logic        clk_sys = 1'b0;
  logic        rst_b, scl, sda_oe_h, sda_oe_d, charge_en_b, supply, pgood, button, rd_done;
  logic [1:0]  mode, zone;
  logic [2:0]  sys, drop, scale;
  logic        pin_oe, allow, meas, trig, req, rails, rd_valid, snap, clr;
  logic [7:0]  rd_data, ctrl, fc, fm;
  logic        tr;
  logic [3:0]  nreq, nrail;
  wire logic   sda_line = ~(sda_oe_h | sda_oe_d);
  int          fails = 0;
  int          n_tests = 0;
  chg_note_s   notes[$];
  chg_note_s   note;

  always #20 clk_sys = ~clk_sys;

  chg_ctrl_regs #(.DEV_ADDR(7'h2A), .WDOG_CYC(2000), .IVAL_CYC(IVAL), .HOLD_CYC(HOLD)) u_chg_ctrl_regs (
    .clk_sys(clk_sys), .rst_b(rst_b), .scl(scl), .sda_i(sda_line), .sda_o(), .sda_oe(sda_oe_d),
    .charge_en_b(charge_en_b), .input_supply_present(supply), .input_power_good(pgood),
    .button_level(button), .status_pin_mode(mode), .temp_zone(zone), .temp_read_done(rd_done),
    .system_rail_target_sel(sys), .status_pin_o(), .status_pin_oe(pin_oe), .charge_allow(allow),
    .warm_volt_drop_sel(drop), .zone_current_scale_sel(scale), .temp_meas_en(meas),
    .temp_check_trigger(trig), .temp_read_req(req), .rails_off(rails));

  chg_host_model #(.DEV_ADDR(7'h2A)) u_chg_host_model (
    .clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_oe(sda_oe_h),
    .rd_data(rd_data), .rd_valid(rd_valid));

  task automatic cmp_rd(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_out(input string n, input logic [20:0] e, input logic [20:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Pulse counters are cleared by the bench at reset, before the trigger write and at each supply cycle, not before every check.
  always @(posedge clk_sys) begin
    nreq <= clr ? 4'h0 : nreq + {3'h0, req};
    nrail <= clr ? 4'h0 : nrail + {3'h0, rails};
  end

  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1 || snap === 1'b1) begin
      if (notes.size() == 0) begin
        fails++;
        $display("[ERR] result with no expectation");
      end else begin
        note = notes.pop_front();
        if (snap === 1'b1) cmp_out(note.name, note.v, {sys, pin_oe, allow, drop, scale, meas, trig, nreq, nrail});
        else cmp_rd(note.name, note.v[7:0], rd_data);
      end
    end
  end

  task automatic chk(input string name, input logic [3:0] nq, input logic [3:0] nr);
    logic o;
    o = mode[1] ? ~ctrl[GPO_BIT] : (mode[0] ? ~button : pgood);
    repeat (8) @(posedge clk_sys);
    notes.push_back('{name, {ctrl[7:5], o, ~ctrl[INHIBIT_BIT] & ~charge_en_b,
      (zone == ZONE_WARM) ? fc[6:4] : 3'h0, (zone == ZONE_WARM || zone == ZONE_COOL) ? fc[2:0] : 3'h0,
      fm[MEAS_EN_BIT], tr, nq, nr}});
    snap <= 1'b1;
    @(posedge clk_sys);
    snap <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    notes.push_back('{$sformatf("reg %h", a), {13'h0000, e}});
    u_chg_host_model.rd(a);
  endtask

  task automatic pwr(input int n);
    supply <= 1'b0;
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (n + 1) @(posedge clk_sys);
    supply <= 1'b1;
  endtask

  initial begin
    repeat (80000) @(posedge clk_sys);
    fails++;
    test_done();
  end

  initial begin
    rst_b = 1'b0;
    {charge_en_b, rd_done, snap, clr} = 4'h0;
    {supply, pgood, button} = 3'h7;
    mode = 2'h2;
    zone = ZONE_NORMAL;
    {ctrl, fc, fm, tr} = {CTRL2_RST, FASTCHG_RST, FAULT_RST, 1'b0};
    void'($urandom(32'hc175));
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    // The pin synchronisers need a few edges after release before a start is seen.
    repeat (4) @(posedge clk_sys);
    reg_rd(ADDR_CTRL2, CTRL2_RST);
    reg_rd(ADDR_THERMISTOR_READ_CONTROL, THERMISTOR_READ_CONTROL_RST);
    reg_rd(ADDR_FAULT, FAULT_RST);
    reg_rd(ADDR_FASTCHG, FASTCHG_RST);
    chk("reset outputs", 4'h0, 4'h0);
    for (int c = 0; c < 8; c++) begin
      ctrl = {c[2:0], 1'($urandom()), 4'h0};
      u_chg_host_model.wr(ADDR_CTRL2, ctrl);
      chk("rail and gpo", 4'h0, 4'h0);
    end
    reg_rd(ADDR_CTRL2, ctrl);
    for (int k = 0; k < 8; k++) begin
      mode <= k[2:1];
      pgood <= k[0];
      button <= k[0];
      @(posedge clk_sys);
      chk("status pin", 4'h0, 4'h0);
    end
    for (int k = 0; k < 4; k++) begin
      charge_en_b <= k[0];
      ctrl[INHIBIT_BIT] = k[1];
      u_chg_host_model.wr(ADDR_CTRL2, ctrl);
      chk("charge allow", 4'h0, 4'h0);
    end
    fc = 8'($urandom()) | 8'h11;
    u_chg_host_model.wr(ADDR_FASTCHG, fc);
    reg_rd(ADDR_FASTCHG, fc);
    for (int z = 0; z < 4; z++) begin
      zone <= 2'(z ^ 2);
      @(posedge clk_sys);
      chk("zone reduction", 4'h0, 4'h0);
    end
    fm = 8'($urandom()) | 8'h04;
    u_chg_host_model.wr(ADDR_FAULT, fm);
    reg_rd(ADDR_FAULT, fm);
    chk("meas enable", 4'h0, 4'h0);
    u_chg_host_model.wr(8'h10, 8'hFF);
    reg_rd(8'h10, 8'h00);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    u_chg_host_model.wr(ADDR_THERMISTOR_READ_CONTROL, 8'h20);
    tr = 1'b1;
    reg_rd(ADDR_THERMISTOR_READ_CONTROL, 8'h20);
    chk("trigger set", 4'h1, 4'h0);
    rd_done <= 1'b1;
    @(posedge clk_sys);
    rd_done <= 1'b0;
    tr = 1'b0;
    chk("trigger cleared", 4'h1, 4'h0);
    u_chg_host_model.wr(ADDR_THERMISTOR_READ_CONTROL, 8'hC0);
    reg_rd(ADDR_THERMISTOR_READ_CONTROL, 8'h80);
    for (int i = 0; i < 2; i++) begin
      if (i == 1) u_chg_host_model.wr(ADDR_THERMISTOR_READ_CONTROL, 8'h00);
      pwr(IVAL * 4 + 24);
      chk("interval reads", (i == 0) ? 4'h4 : 4'h0, 4'h0);
    end
    ctrl = 8'hA2;
    u_chg_host_model.wr(ADDR_CTRL2, ctrl);
    pwr(1);
    repeat (1900) @(posedge clk_sys);
    chk("watchdog early", 4'h0, 4'h0);
    repeat (300) @(posedge clk_sys);
    {ctrl, fc, fm} = {CTRL2_RST, FASTCHG_RST, FAULT_RST};
    chk("watchdog reset", 4'h0, 4'(HOLD));
    reg_rd(ADDR_THERMISTOR_READ_CONTROL, THERMISTOR_READ_CONTROL_RST);
    ctrl = 8'hA2;
    u_chg_host_model.wr(ADDR_CTRL2, ctrl);
    pwr(1);
    reg_rd(ADDR_CTRL2, ctrl);
    repeat (2100) @(posedge clk_sys);
    chk("watchdog served", 4'h0, 4'h0);
    repeat (20) @(posedge clk_sys);
    test_done();
  end
endmodule
